/* include/hcrb_cfg.svh */
/*
 Constants of the host configuration register bank: offsets, banks, bit
 positions, reset values and serial memory timing.
 Assumes a 20 MHz ref_clk and a 16-bit word-wide host bus.
*/
`ifndef HCRB_CFG_SVH
`define HCRB_CFG_SVH

`define HCRB_OFF_BANKSEL 4'hE
`define HCRB_OFF_W0 4'h0
`define HCRB_OFF_W1 4'h2
`define HCRB_OFF_W2 4'h4
`define HCRB_OFF_W3 4'h6

`define HCRB_BANK_BASE 6'h00
`define HCRB_BANK_MAC 6'h02
`define HCRB_BANK_CTL 6'h03

`define HCRB_BAR_RESET 11'h018
`define HCRB_SPEED_RESET 2'h0
`define HCRB_SPEED_SLOW 2'h3
`define HCRB_CFG_SPEED_BIT 1

`define HCRB_SWEN_BIT 4
`define HCRB_DIN_BIT 3
`define HCRB_DO_BIT 2
`define HCRB_SK_BIT 1
`define HCRB_CS_BIT 0

`define HCRB_TX_DONE_BIT 12
`define HCRB_TX_FAIL_BIT 11
`define HCRB_RX_DONE_BIT 4
`define HCRB_RX_FAIL_BIT 3
`define HCRB_SRST_BIT 0

`define HCRB_EE_ADDR_BAR 6'h00
`define HCRB_EE_ADDR_MACL 6'h01
`define HCRB_EE_ADDR_MACM 6'h02
`define HCRB_EE_ADDR_MACH 6'h03
`define HCRB_EE_ADDR_PARM 6'h06
`define HCRB_EE_LAST_IDX 3'h4
`define HCRB_EE_READ_CMD 3'h6
`define HCRB_EE_TOTAL_RISES 5'h1A
`define HCRB_STRAP_WAIT 2'h3

`define HCRB_CLK_PERIOD_NS 50
`define HCRB_SK_HALF_NS 500
`define HCRB_SK_HALF_CYC ((`HCRB_SK_HALF_NS + `HCRB_CLK_PERIOD_NS - 1) / `HCRB_CLK_PERIOD_NS)

`endif

/* include/hcrb_pkg.sv */
/*
 Types of the host configuration register bank: phases and state records.
 Assumes hcrb_cfg.svh is on the include path.
*/
package hcrb_pkg;

    typedef enum logic [1:0] {T_BOOT, T_LOAD, T_RUN} hcrb_top_phase_t;
    typedef enum logic [1:0] {L_IDLE, L_RUN, L_GAP} hcrb_ld_phase_t;

    typedef struct packed {
        hcrb_top_phase_t phase;
        logic [1:0] boot_cnt;
        logic [5:0] bank;
        logic [7:0] bar_hi;
        logic [2:0] bar_lo;
        logic [15:0] mac_lo;
        logic [15:0] mac_mid;
        logic [15:0] mac_hi;
        logic [1:0] speed;
        logic sw_en;
        logic [2:0] sw_bits;
        logic soft_rst;
        logic [3:0] st_bits;
        logic di_s1;
        logic di_s2;
        logic strap_s1;
        logic strap_s2;
        logic pin_sk;
        logic pin_cs;
        logic pin_do;
        logic ld_start;
        logic loading;
        logic [15:0] rdata;
        logic rvalid;
    } hcrb_top_state_t;

    typedef struct packed {
        hcrb_ld_phase_t phase;
        logic busy;
        logic [2:0] idx;
        logic [4:0] div;
        logic [4:0] rises;
        logic [8:0] cmd;
        logic [15:0] rx;
        logic sk;
        logic cs;
        logic dout;
        logic word_valid;
        logic [15:0] word;
    } hcrb_ld_state_t;

endpackage : hcrb_pkg

/* include/hcrb_ld_if.sv */
/*
 Link between the register bank and its serial memory loader.
 Assumes both ends share ref_clk.
*/
`timescale 1ns/100ps
interface hcrb_ld_if;
    logic start;
    logic din;
    logic busy;
    logic word_valid;
    logic [2:0] word_idx;
    logic [15:0] word;
    logic sk;
    logic cs;
    logic dout;

    modport loader (input start, input din, output busy, output word_valid,
        output word_idx, output word, output sk, output cs, output dout);
    modport owner (output start, output din, input busy, input word_valid,
        input word_idx, input word, input sk, input cs, input dout);
endinterface : hcrb_ld_if

/* src/hcrb_loader.sv */
/*
 Serial configuration memory loader: reads words 0x0..0x3 and 0x6 with
 three-wire read commands, one word per chip-select frame.
 Assumes din is already synchronised to ref_clk.
*/
`timescale 1ns/100ps
`include "hcrb_cfg.svh"
module hcrb_loader import hcrb_pkg::*; (
    // clock and control
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    // link to register bank
    hcrb_ld_if.loader lp
);
    hcrb_ld_state_t st;
    hcrb_ld_state_t next_st;

    function automatic logic [5:0] ee_addr(input logic [2:0] idx);
        case (idx)
            3'h0: ee_addr = `HCRB_EE_ADDR_BAR;
            3'h1: ee_addr = `HCRB_EE_ADDR_MACL;
            3'h2: ee_addr = `HCRB_EE_ADDR_MACM;
            3'h3: ee_addr = `HCRB_EE_ADDR_MACH;
            default: ee_addr = `HCRB_EE_ADDR_PARM;
        endcase
    endfunction : ee_addr

    localparam logic [4:0] HALF_LAST = 5'(`HCRB_SK_HALF_CYC - 1);

    always_comb begin
        next_st = st;
        next_st.word_valid = 1'b0;
        case (st.phase)
            L_IDLE: begin
                if (lp.start) begin
                    next_st.phase = L_RUN;
                    next_st.busy = 1'b1;
                    next_st.idx = 3'h0;
                    next_st.cs = 1'b1;
                    next_st.sk = 1'b0;
                    next_st.div = 5'h0;
                    next_st.rises = 5'h0;
                    next_st.cmd = {`HCRB_EE_READ_CMD, ee_addr(3'h0)};
                    next_st.dout = 1'(`HCRB_EE_READ_CMD >> 2);
                end
            end
            L_RUN: begin
                if (st.div == HALF_LAST) begin
                    next_st.div = 5'h0;
                    if (!st.sk) begin
                        // memory presents data before the rising edge
                        next_st.sk = 1'b1;
                        next_st.rx = {st.rx[14:0], lp.din};
                        next_st.rises = st.rises + 5'h1;
                    end else begin
                        next_st.sk = 1'b0;
                        if (st.rises == `HCRB_EE_TOTAL_RISES) begin
                            next_st.cs = 1'b0;
                            next_st.dout = 1'b0;
                            next_st.word = st.rx;
                            next_st.word_valid = 1'b1;
                            next_st.phase = L_GAP;
                        end else begin
                            next_st.dout = st.cmd[7];
                            next_st.cmd = {st.cmd[7:0], 1'b0};
                        end
                    end
                end else begin
                    next_st.div = st.div + 5'h1;
                end
            end
            L_GAP: begin
                // chip select low for one half period between words
                if (st.div == HALF_LAST) begin
                    next_st.div = 5'h0;
                    if (st.idx == `HCRB_EE_LAST_IDX) begin
                        next_st.phase = L_IDLE;
                        next_st.busy = 1'b0;
                    end else begin
                        next_st.idx = st.idx + 3'h1;
                        next_st.phase = L_RUN;
                        next_st.cs = 1'b1;
                        next_st.rises = 5'h0;
                        next_st.cmd = {`HCRB_EE_READ_CMD, ee_addr(st.idx + 3'h1)};
                        next_st.dout = 1'(`HCRB_EE_READ_CMD >> 2);
                    end
                end else begin
                    next_st.div = st.div + 5'h1;
                end
            end
            default: next_st.phase = L_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign lp.busy = st.busy;
    assign lp.word_valid = st.word_valid;
    assign lp.word_idx = st.idx;
    assign lp.word = st.word;
    assign lp.sk = st.sk;
    assign lp.cs = st.cs;
    assign lp.dout = st.dout;
endmodule : hcrb_loader

/* src/hcrb_top.sv */
/*
 Host configuration register bank: base address, station address words,
 bank select, internal bus speed, serial memory control, self-test
 status and soft reset.
 Assumes the host bus strobes are synchronous to ref_clk and last one
 cycle; memory pins and the strap come from outside and are synchronised.
*/
`timescale 1ns/100ps
`include "hcrb_cfg.svh"
module hcrb_top import hcrb_pkg::*; (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic ce,
    // host bus
    input wire logic [15:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [15:0] host_wdata,
    output logic [15:0] host_rdata,
    output logic host_rdata_valid,
    // serial configuration memory
    input wire logic memory_enable_strap,
    input wire logic memory_serial_in_pin,
    output logic memory_serial_out_pin,
    output logic memory_serial_clock_pin,
    output logic memory_chip_select_pin,
    // self-test results from the memories
    input wire logic tx_selftest_done,
    input wire logic tx_selftest_failed,
    input wire logic rx_selftest_done,
    input wire logic rx_selftest_failed,
    // to the core
    output logic soft_reset_active,
    output logic [1:0] bus_speed_select,
    output logic [47:0] station_addr,
    output logic config_load_busy
);
    hcrb_top_state_t st;
    hcrb_top_state_t next_st;
    hcrb_ld_if ld ();

    hcrb_loader u_loader (
        .ref_clk(ref_clk),
        .srst(srst),
        .ce(ce),
        .lp(ld.loader)
    );

    function automatic logic reg_hit(input logic [5:0] bank, input logic [3:0] off,
            input logic [5:0] want_bank, input logic [3:0] want_off);
        reg_hit = (bank == want_bank) && (off == want_off);
    endfunction : reg_hit

    function automatic logic [15:0] read_word(input hcrb_top_state_t s,
            input logic [3:0] off);
        logic [15:0] v;
        v = 16'h0000;
        if (off == `HCRB_OFF_BANKSEL) begin
            v[5:0] = s.bank;
        end else if (reg_hit(s.bank, off, `HCRB_BANK_BASE, `HCRB_OFF_W0)) begin
            v = {s.bar_hi, s.bar_lo, 5'h00};
        end else if (reg_hit(s.bank, off, `HCRB_BANK_MAC, `HCRB_OFF_W0)) begin
            v = s.mac_lo;
        end else if (reg_hit(s.bank, off, `HCRB_BANK_MAC, `HCRB_OFF_W1)) begin
            v = s.mac_mid;
        end else if (reg_hit(s.bank, off, `HCRB_BANK_MAC, `HCRB_OFF_W2)) begin
            v = s.mac_hi;
        end else if (reg_hit(s.bank, off, `HCRB_BANK_CTL, `HCRB_OFF_W0)) begin
            v[1:0] = s.speed;
        end else if (reg_hit(s.bank, off, `HCRB_BANK_CTL, `HCRB_OFF_W1)) begin
            v[`HCRB_SWEN_BIT] = s.sw_en;
            v[`HCRB_DIN_BIT] = s.di_s2;
            v[`HCRB_DO_BIT] = s.sw_bits[2];
            v[`HCRB_SK_BIT] = s.sw_bits[1];
            v[`HCRB_CS_BIT] = s.sw_bits[0];
        end else if (reg_hit(s.bank, off, `HCRB_BANK_CTL, `HCRB_OFF_W2)) begin
            v[`HCRB_TX_DONE_BIT] = s.st_bits[3];
            v[`HCRB_TX_FAIL_BIT] = s.st_bits[2];
            v[`HCRB_RX_DONE_BIT] = s.st_bits[1];
            v[`HCRB_RX_FAIL_BIT] = s.st_bits[0];
        end else if (reg_hit(s.bank, off, `HCRB_BANK_CTL, `HCRB_OFF_W3)) begin
            v[`HCRB_SRST_BIT] = s.soft_rst;
        end
        // unmapped offsets and reserved bits stay zero
        read_word = v;
    endfunction : read_word

    logic sel;
    logic [3:0] off;

    assign sel = (host_addr[15:8] == st.bar_hi) && (host_addr[7:5] == st.bar_lo);
    assign off = host_addr[3:0];
    assign ld.start = st.ld_start;
    assign ld.din = st.di_s2;

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.ld_start = 1'b0;

        // pins from outside the clock domain
        next_st.di_s1 = memory_serial_in_pin;
        next_st.di_s2 = st.di_s1;
        next_st.strap_s1 = memory_enable_strap;
        next_st.strap_s2 = st.strap_s1;

        // self-test flags are live levels from the memories
        next_st.st_bits = {tx_selftest_done, tx_selftest_failed,
            rx_selftest_done, rx_selftest_failed};

        case (st.phase)
            T_BOOT: begin
                // wait for the strap to clear its synchroniser
                if (st.boot_cnt == `HCRB_STRAP_WAIT) begin
                    if (st.strap_s2) begin
                        next_st.phase = T_LOAD;
                        next_st.ld_start = 1'b1;
                        next_st.loading = 1'b1;
                    end else begin
                        // reset values already give base 0x300 and speed 00
                        next_st.phase = T_RUN;
                    end
                end else begin
                    next_st.boot_cnt = st.boot_cnt + 2'h1;
                end
            end
            T_LOAD: begin
                if (!st.ld_start && !ld.busy) begin
                    next_st.phase = T_RUN;
                    next_st.loading = 1'b0;
                end
            end
            T_RUN: next_st.phase = T_RUN;
            default: next_st.phase = T_BOOT;
        endcase

        // host writes; later loader words below override on a clash
        if (sel && host_wr) begin
            if (off == `HCRB_OFF_BANKSEL) begin
                next_st.bank = host_wdata[5:0];
            end
            if (reg_hit(st.bank, off, `HCRB_BANK_BASE, `HCRB_OFF_W0)) begin
                next_st.bar_hi = host_wdata[15:8];
                next_st.bar_lo = host_wdata[7:5];
            end
            if (reg_hit(st.bank, off, `HCRB_BANK_MAC, `HCRB_OFF_W0)) begin
                next_st.mac_lo = host_wdata;
            end
            if (reg_hit(st.bank, off, `HCRB_BANK_MAC, `HCRB_OFF_W1)) begin
                next_st.mac_mid = host_wdata;
            end
            if (reg_hit(st.bank, off, `HCRB_BANK_MAC, `HCRB_OFF_W2)) begin
                next_st.mac_hi = host_wdata;
            end
            if (reg_hit(st.bank, off, `HCRB_BANK_CTL, `HCRB_OFF_W0)) begin
                next_st.speed = host_wdata[1:0];
            end
            if (reg_hit(st.bank, off, `HCRB_BANK_CTL, `HCRB_OFF_W1)) begin
                next_st.sw_en = host_wdata[`HCRB_SWEN_BIT];
                next_st.sw_bits = {host_wdata[`HCRB_DO_BIT],
                    host_wdata[`HCRB_SK_BIT], host_wdata[`HCRB_CS_BIT]};
            end
            if (reg_hit(st.bank, off, `HCRB_BANK_CTL, `HCRB_OFF_W3)) begin
                next_st.soft_rst = host_wdata[`HCRB_SRST_BIT];
            end
        end

        if (sel && host_rd) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = read_word(st, off);
        end

        // words arriving from the serial memory
        if (ld.word_valid) begin
            case (ld.word_idx)
                3'h0: begin
                    next_st.bar_hi = ld.word[15:8];
                    next_st.bar_lo = ld.word[7:5];
                end
                3'h1: next_st.mac_lo = ld.word;
                3'h2: next_st.mac_mid = ld.word;
                3'h3: next_st.mac_hi = ld.word;
                default: begin
                    next_st.speed = ld.word[`HCRB_CFG_SPEED_BIT] ?
                        `HCRB_SPEED_SLOW : `HCRB_SPEED_RESET;
                end
            endcase
        end

        // pin owner follows the enable bit; one register stage to the pad
        if (st.sw_en) begin
            next_st.pin_do = st.sw_bits[2];
            next_st.pin_sk = st.sw_bits[1];
            next_st.pin_cs = st.sw_bits[0];
        end else begin
            // software bits are held but do not reach the pins
            next_st.pin_do = ld.dout;
            next_st.pin_sk = ld.sk;
            next_st.pin_cs = ld.cs;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '0;
            st.phase <= T_BOOT;
            {st.bar_hi, st.bar_lo} <= `HCRB_BAR_RESET;
            st.speed <= `HCRB_SPEED_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // soft reset goes to the core only; this bank keeps its contents
    assign soft_reset_active = st.soft_rst;
    assign bus_speed_select = st.speed;
    assign station_addr = {st.mac_hi, st.mac_mid, st.mac_lo};
    assign config_load_busy = st.loading;
    assign host_rdata = st.rdata;
    assign host_rdata_valid = st.rvalid;
    assign memory_serial_out_pin = st.pin_do;
    assign memory_serial_clock_pin = st.pin_sk;
    assign memory_chip_select_pin = st.pin_cs;
endmodule : hcrb_top

/* verification/hcrb_mem_model.sv */
/*
 Behavioural serial configuration memory: read command 110 plus six
 address bits, then a dummy bit and sixteen data bits, MSB first.
 Assumes the device changes its data output only while the clock is low.
*/
`timescale 1ns/100ps
module hcrb_mem_model (
    // pins as seen from the memory
    input wire logic cs,
    input wire logic sk,
    input wire logic din,
    output logic dout
);
    logic [15:0] mem [0:63];
    logic [8:0] cmd;
    int n;
    initial begin
        mem = '{default: 16'h0000};
        mem[0] = 16'h0540;
        mem[1] = 16'h89AB;
        mem[2] = 16'h4567;
        mem[3] = 16'h0123;
        mem[6] = 16'h0002;
        dout = 1'b0;
        cmd = 9'h000;
        n = 0;
    end
    always @(posedge cs) n = 0;
    // no pull on the line: a released output shows the inverse of its last bit
    always @(negedge cs) dout = ~dout;
    always @(posedge sk) begin
        if (cs && n < 9) cmd = {cmd[7:0], din};
        if (cs) n = n + 1;
    end
    // data moves after the falling clock so it is settled at the next rise
    always @(negedge sk) begin
        if (cs && n >= 9 && n <= 25) dout = (n == 9 || cmd[8:6] != 3'b110) ? 1'b0 : mem[cmd[5:0]][25 - n];
    end
endmodule : hcrb_mem_model

/* verification/hcrb_monitor.sv */
/*
 Concurrent checks on the ports of the host configuration register bank.
 Assumes the host touches offset 0xE only at the bank's own base.
*/
`timescale 1ns/100ps
module hcrb_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // host bus
    input wire logic [15:0] host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic host_rdata_valid,
    // memory pins and self-test flags
    input wire logic memory_serial_out_pin,
    input wire logic memory_serial_clock_pin,
    input wire logic memory_chip_select_pin,
    input wire logic tx_selftest_done,
    input wire logic tx_selftest_failed,
    input wire logic rx_selftest_done,
    input wire logic rx_selftest_failed,
    // core side
    input wire logic soft_reset_active,
    input wire logic [1:0] bus_speed_select,
    input wire logic config_load_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // bank tracked from the bus, not taken from the design
    logic [5:0] bank;
    logic [15:0] wd;
    logic [11:0] busy_cnt;
    wire [3:0] off = host_addr[3:0];
    wire w3 = host_wr && bank == 6'h03;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bank <= 6'h00;
            busy_cnt <= 12'h000;
        end else begin
            if (host_wr && off == 4'hE) bank <= host_wdata[5:0];
            busy_cnt <= config_load_busy ? busy_cnt + 12'h001 : 12'h000;
        end
        if (host_wr) wd <= host_wdata;
    end
    chk_read_cause: assert property (host_rdata_valid |-> $past(host_rd))
        else $error("read data without a read strobe");
    chk_speed_rsvd: assert property (host_rdata_valid && $past(bank) == 6'h03
        && $past(off) == 4'h0 |-> host_rdata[15:2] == 14'h0000)
        else $error("speed register reserved bits not zero");
    chk_status_word: assert property (host_rdata_valid && $past(bank) == 6'h03
        && $past(off) == 4'h4 |-> host_rdata == {3'h0, $past(tx_selftest_done, 2),
        $past(tx_selftest_failed, 2), 6'h00, $past(rx_selftest_done, 2),
        $past(rx_selftest_failed, 2), 3'h0})
        else $error("self-test word wrong");
    chk_pin_follow: assert property (w3 && off == 4'h2 && host_wdata[4] |-> ##2
        {memory_serial_out_pin, memory_serial_clock_pin, memory_chip_select_pin}
        == $past(host_wdata[2:0], 2)) else $error("memory pins do not follow control bits");
    chk_speed_write: assert property (w3 && off == 4'h0 |=> ##[0:1] bus_speed_select == wd[1:0])
        else $error("speed output does not follow write");
    chk_soft_reset: assert property (w3 && off == 4'h6 |=> ##[0:1] soft_reset_active == wd[0])
        else $error("soft reset output does not follow write");
    chk_reset_clear: assert property ($fell(srst) |-> !soft_reset_active
        && bus_speed_select == 2'h0 && !memory_chip_select_pin) else $error("bad value after reset");
    chk_load_bound: assert property (busy_cnt < 12'hBB8)
        else $error("memory load runs too long");
    cover property ($fell(config_load_busy));
    cover property (host_rdata_valid && $past(bank) == 6'h03 && $past(off) == 4'h2);
    cover property ($rose(soft_reset_active));
endmodule : hcrb_monitor

bind hcrb_top hcrb_monitor u_mon (.ref_clk, .srst, .host_addr, .host_wr, .host_rd,
    .host_wdata, .host_rdata, .host_rdata_valid, .memory_serial_out_pin,
    .memory_serial_clock_pin, .memory_chip_select_pin, .tx_selftest_done,
    .tx_selftest_failed, .rx_selftest_done, .rx_selftest_failed, .soft_reset_active,
    .bus_speed_select, .config_load_busy);

/* verification/tb_top.sv */
/*
 Self-checking bench for the host configuration register bank: register
 map, software memory access, self-test status, soft reset, memory load.
 Assumes the memory model stands on the device's serial pins.
*/
`timescale 1ns/100ps
module tb_top;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic host_wr = 1'b0;
    logic host_rd = 1'b0;
    logic [15:0] host_addr = 16'h0000;
    logic [15:0] host_wdata = 16'h0000;
    logic memory_enable_strap = 1'b0;
    logic tx_selftest_done = 1'b0, tx_selftest_failed = 1'b0;
    logic rx_selftest_done = 1'b0, rx_selftest_failed = 1'b0;
    logic [15:0] host_rdata;
    logic host_rdata_valid, soft_reset_active, config_load_busy;
    logic memory_serial_in_pin, memory_serial_out_pin;
    logic memory_serial_clock_pin, memory_chip_select_pin;
    logic [1:0] bus_speed_select;
    logic [47:0] station_addr;
    logic [15:0] base = 16'h0300;
    logic [31:0] rng = 32'h00003D27;
    logic [15:0] expq [$];
    logic [15:0] mid, hi;
    logic b;
    int fails = 0;
    int checked = 0;
    int i;

    always #25 ref_clk = ~ref_clk;

    hcrb_top uut (.ref_clk, .srst, .ce, .host_addr, .host_wr, .host_rd, .host_wdata,
        .host_rdata, .host_rdata_valid, .memory_enable_strap, .memory_serial_in_pin,
        .memory_serial_out_pin, .memory_serial_clock_pin, .memory_chip_select_pin,
        .tx_selftest_done, .tx_selftest_failed, .rx_selftest_done, .rx_selftest_failed,
        .soft_reset_active, .bus_speed_select, .station_addr, .config_load_busy);
    hcrb_mem_model mem (.cs(memory_chip_select_pin), .sk(memory_serial_clock_pin),
        .din(memory_serial_out_pin), .dout(memory_serial_in_pin));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // one write, or one read whose expected word is queued for the watcher
    task automatic acc(input logic w, input logic [3:0] off, input logic [15:0] d);
        @(posedge ref_clk);
        if (!w) expq.push_back(d);
        host_addr <= base | {12'h000, off};
        host_wdata <= d;
        host_wr <= w;
        host_rd <= !w;
        @(posedge ref_clk);
        host_wr <= 1'b0;
        host_rd <= 1'b0;
    endtask : acc

    task automatic bang(input logic d, input logic s);
        acc(1'b1, 4'h2, {11'h000, 1'b1, 1'b0, d, s, 1'b1});
    endtask : bang

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // a valid with nothing queued is itself a mismatch
    always @(posedge ref_clk) begin
        if (host_rdata_valid === 1'b1) begin
            if (expq.size() == 0) check(16'h0001, 16'h0000);
            else check(host_rdata, expq.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        end_of_test;
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        rng = xs(rng);
        mid = rng[15:0];
        hi = rng[31:16];
        acc(1'b1, 4'hE, 16'hFFC2);
        acc(1'b1, 4'h2, mid);
        acc(1'b1, 4'h4, hi);
        acc(1'b0, 4'h2, mid);
        acc(1'b0, 4'h4, hi);
        // a write at another base must be ignored
        base = 16'h0700;
        acc(1'b1, 4'h2, ~mid);
        base = 16'h0300;
        acc(1'b0, 4'h2, mid);
        acc(1'b1, 4'hE, 16'h0001);
        acc(1'b0, 4'h0, 16'h0000);
        acc(1'b0, 4'hE, 16'h0001);
        acc(1'b1, 4'hE, 16'h0003);
        for (i = 0; i < 4; i++) begin
            acc(1'b1, 4'h0, 16'hFFFC | i[15:0]);
            acc(1'b0, 4'h0, i[15:0]);
        end
        acc(1'b1, 4'h0, 16'h0000);
        for (i = 0; i < 8; i++) begin
            acc(1'b1, 4'h2, 16'hFFE0 | i[15:0]);
            acc(1'b0, 4'h2, {12'h000, memory_serial_in_pin, i[2:0]});
            #1 check({13'h0000, memory_serial_out_pin, memory_serial_clock_pin, memory_chip_select_pin}, 16'h0000);
        end
        // software read of memory word 2 by toggling the pins
        for (i = 0; i < 26; i++) begin
            b = (i < 9) ? 1'(9'h182 >> (8 - i)) : 1'b0;
            bang(b, 1'b0);
            if (i >= 10) begin
                repeat (4) @(posedge ref_clk);
                acc(1'b0, 4'h2, {11'h000, 1'b1, 1'(16'h4567 >> (25 - i)), 3'h1});
            end
            bang(b, 1'b1);
        end
        acc(1'b1, 4'h2, 16'h0010);
        acc(1'b1, 4'h2, 16'h0000);
        for (i = 0; i < 3; i++) begin
            rng = xs(rng);
            {tx_selftest_done, tx_selftest_failed, rx_selftest_done, rx_selftest_failed} <= rng[3:0];
            repeat (3) @(posedge ref_clk);
            acc(1'b0, 4'h4, {3'h0, rng[3:2], 6'h00, rng[1:0], 3'h0});
        end
        acc(1'b1, 4'h6, 16'hFFFF);
        acc(1'b0, 4'h6, 16'h0001);
        check({15'h0000, soft_reset_active}, 16'h0001);
        acc(1'b1, 4'hE, 16'h0002);
        acc(1'b0, 4'h4, hi);
        #1 check(station_addr[31:16], mid);
        acc(1'b1, 4'hE, 16'h0003);
        acc(1'b1, 4'h6, 16'h0000);
        // second reset with the memory strapped in
        memory_enable_strap <= 1'b1;
        srst <= 1'b1;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        for (i = 0; i < 50 && config_load_busy !== 1'b1; i++) @(posedge ref_clk);
        for (i = 0; i < 4000 && config_load_busy !== 1'b0; i++) @(posedge ref_clk);
        #1 check({15'h0000, config_load_busy}, 16'h0000);
        check(station_addr[47:32], 16'h0123);
        check(station_addr[31:16], 16'h4567);
        check(station_addr[15:0], 16'h89AB);
        check({14'h0000, bus_speed_select}, 16'h0003);
        base = 16'h0540;
        acc(1'b1, 4'hE, 16'h0002);
        acc(1'b0, 4'h2, 16'h4567);
        acc(1'b1, 4'hE, 16'h0003);
        acc(1'b1, 4'h0, 16'h0001);
        acc(1'b0, 4'h0, 16'h0001);
        repeat (4) @(posedge ref_clk);
        end_of_test;
    end
endmodule : tb_top
